// File: design/smbus_config_target_port.sv
// Select-gated SMBus target giving byte access to the serializer configuration registers.
// Assumes open-drain SCL/SDA resolved outside; pins and select are asynchronous to ref_clk_in.
// Notes on behaviour
// - On matching its own address the device acknowledges by pulling data low.
// - The host sends an 8-bit pointer, which the device loads and acknowledges low.
// - After acknowledging the read address the device shifts out the pointed byte MSB first.
// - Devices sharing one address are told apart by select, and a deselected one stays off the bus.
// - The address resolution protocol is not supported and gets no response.
// - The bus address is rewritable through register 0.
// - In a chain, the chain select output drives the next device's select.
// - Out of reset the device answers to target address 1010111b.
// - Register 0 holds the address in bits 7:1, default 57h, and software reset keeps it.
`timescale 1ns/1ps
`default_nettype none

module smbus_config_target_port
  import smbus_cfg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // SMBus pins
  input wire logic port_select_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Device controls
  output logic chain_select_out,
  output logic analog_disable_out
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_pipe_r;
  logic rst_n;

  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rst_pipe_r <= 2'h0;
    else
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
  end

  assign rst_n = rst_pipe_r[1];

  // ----------------------------------------------------------------
  // State and bus events
  // ----------------------------------------------------------------
  port_state_s st_r;
  port_state_s st_nxt;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [7:0] rdata;

  assign scl_rise = st_r.scl_s2 & ~st_r.scl_d;
  assign scl_fall = ~st_r.scl_s2 & st_r.scl_d;
  assign start_seen = st_r.scl_s2 & st_r.scl_d & st_r.sda_d & ~st_r.sda_s2;
  assign stop_seen = st_r.scl_s2 & st_r.scl_d & ~st_r.sda_d & st_r.sda_s2;

  // Out-of-range pointers read as zero rather than aliasing
  always_comb
  begin
    if (st_r.ptr == REG_DEV_ADDR)
      rdata = {st_r.dev_addr, 1'b0};
    else if (st_r.ptr < NUM_REGS)
      rdata = st_r.cfg[st_r.ptr[2:0]];
    else
      rdata = 8'h00;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.scl_s1 = scl_in;
    st_nxt.scl_s2 = st_r.scl_s1;
    st_nxt.scl_d = st_r.scl_s2;
    st_nxt.sda_s1 = sda_in;
    st_nxt.sda_s2 = st_r.sda_s1;
    st_nxt.sda_d = st_r.sda_s2;
    st_nxt.cs_s1 = port_select_in;
    st_nxt.cs_s2 = st_r.cs_s1;
    st_nxt.chain = (st_r.cfg[REG_CHAIN_CFG[2:0]][GPIO_MODE_LSB +: 4] == GPIO_MODE_GP_OUT)
      && st_r.cfg[REG_CHAIN_CFG[2:0]][GPIO_OE_BIT]
      && st_r.cfg[REG_CHAIN_OUT[2:0]][CHAIN_BIT];
    if (!st_r.cs_s2)
    begin
      // Deselected: traffic belongs to another target
      st_nxt.fsm = ST_IDLE;
      st_nxt.drive = 1'b0;
    end
    else if (start_seen)
    begin
      // Repeated START lands here too, keeping the loaded pointer
      st_nxt.fsm = ST_ADDR;
      st_nxt.cnt = 4'h0;
      st_nxt.drive = 1'b0;
    end
    else if (stop_seen)
    begin
      st_nxt.fsm = ST_IDLE;
      st_nxt.drive = 1'b0;
    end
    else if (scl_rise)
    begin
      case (st_r.fsm)
        ST_ADDR, ST_PTR, ST_WDATA:
        begin
          st_nxt.shreg = {st_r.shreg[6:0], st_r.sda_s2};
          st_nxt.cnt = 4'(st_r.cnt + 4'h1);
        end
        ST_RDATA_ACK:
        begin
          st_nxt.mack = ~st_r.sda_s2;
          if (!st_r.sda_s2)
            st_nxt.ptr = 8'(st_r.ptr + 8'h01);
        end
        default:
        begin
        end
      endcase
    end
    else if (scl_fall)
    begin
      case (st_r.fsm)
        ST_ADDR:
        begin
          if (st_r.cnt == BITS_PER_BYTE)
          begin
            // The resolution default address is never claimed
            if (st_r.shreg[7:1] == st_r.dev_addr && st_r.shreg[7:1] != ARP_DEFAULT_ADDR)
            begin
              st_nxt.drive = 1'b1;
              st_nxt.rw = st_r.shreg[0];
              st_nxt.fsm = ST_ADDR_ACK;
            end
            else
              st_nxt.fsm = ST_IGNORE;
          end
        end
        ST_ADDR_ACK:
        begin
          st_nxt.cnt = 4'h0;
          if (st_r.rw)
          begin
            st_nxt.shreg = rdata;
            st_nxt.drive = ~rdata[7];
            st_nxt.fsm = ST_RDATA;
          end
          else
          begin
            st_nxt.drive = 1'b0;
            st_nxt.fsm = ST_PTR;
          end
        end
        ST_PTR:
        begin
          if (st_r.cnt == BITS_PER_BYTE)
          begin
            st_nxt.ptr = st_r.shreg;
            st_nxt.drive = 1'b1;
            st_nxt.fsm = ST_PTR_ACK;
          end
        end
        ST_PTR_ACK, ST_WDATA_ACK:
        begin
          st_nxt.cnt = 4'h0;
          st_nxt.drive = 1'b0;
          st_nxt.fsm = ST_WDATA;
        end
        ST_WDATA:
        begin
          if (st_r.cnt == BITS_PER_BYTE)
          begin
            if (st_r.ptr == REG_DEV_ADDR)
              st_nxt.dev_addr = st_r.shreg[7:1];
            else if (st_r.ptr == REG_RESET && st_r.shreg[SRST_BIT])
              st_nxt.cfg = CFG_DEFAULT;
            else if (st_r.ptr == REG_RESET)
              st_nxt.cfg[REG_RESET[2:0]] = st_r.shreg & RESET_WMASK;
            else if (st_r.ptr < NUM_REGS)
              st_nxt.cfg[st_r.ptr[2:0]] = st_r.shreg;
            st_nxt.drive = 1'b1;
            st_nxt.fsm = ST_WDATA_ACK;
          end
        end
        ST_RDATA:
        begin
          if (st_r.cnt == LAST_BIT_IDX)
          begin
            st_nxt.drive = 1'b0;
            st_nxt.cnt = 4'h0;
            st_nxt.fsm = ST_RDATA_ACK;
          end
          else
          begin
            st_nxt.shreg = {st_r.shreg[6:0], 1'b0};
            st_nxt.drive = ~st_r.shreg[6];
            st_nxt.cnt = 4'(st_r.cnt + 4'h1);
          end
        end
        ST_RDATA_ACK:
        begin
          if (st_r.mack)
          begin
            st_nxt.shreg = rdata;
            st_nxt.drive = ~rdata[7];
            st_nxt.fsm = ST_RDATA;
          end
          else
            st_nxt.fsm = ST_IGNORE;
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= STATE_RESET;
    else
      st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open drain: the pin is only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe_out = st_r.drive;
  assign chain_select_out = st_r.chain;
  assign analog_disable_out = st_r.cfg[REG_RESET[2:0]][ANALOG_DIS_BIT];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n);

  logic byte_end;
  assign byte_end = st_r.cs_s2 & scl_fall & (st_r.cnt == BITS_PER_BYTE);

  no_drive_unselected_a: assert property (!st_r.cs_s2 |=> !sda_oe_out)
    else $error("data driven while deselected");
  addr_ack_a: assert property (byte_end && st_r.fsm == ST_ADDR && st_r.shreg[7:1] == st_r.dev_addr
    && st_r.dev_addr != ARP_DEFAULT_ADDR |=> sda_oe_out && st_r.fsm == ST_ADDR_ACK)
    else $error("own address not acknowledged");
  ptr_load_a: assert property (byte_end && st_r.fsm == ST_PTR |=>
    st_r.ptr == $past(st_r.shreg) && sda_oe_out)
    else $error("pointer not loaded or acknowledged");
  arp_ignore_a: assert property (byte_end && st_r.fsm == ST_ADDR
    && st_r.shreg[7:1] == ARP_DEFAULT_ADDR |=> st_r.fsm == ST_IGNORE && !sda_oe_out)
    else $error("resolution address answered");
  read_msb_a: assert property (st_r.cs_s2 && scl_fall && st_r.fsm == ST_ADDR_ACK && st_r.rw
    |=> sda_oe_out == ~$past(rdata[7]) && st_r.fsm == ST_RDATA)
    else $error("read data MSB wrong");
  addr_write_a: assert property (byte_end && st_r.fsm == ST_WDATA && st_r.ptr == REG_DEV_ADDR
    |=> st_r.dev_addr == $past(st_r.shreg[7:1]))
    else $error("address register not written");
  soft_reset_keep_a: assert property (byte_end && st_r.fsm == ST_WDATA && st_r.ptr == REG_RESET
    && st_r.shreg[SRST_BIT] |=> st_r.cfg == CFG_DEFAULT && $stable(st_r.dev_addr))
    else $error("software reset changed address or kept settings");
  reset_addr_a: assert property ($rose(rst_n) |-> st_r.dev_addr == DEF_TARGET_ADDR)
    else $error("wrong address after reset");
  chain_follow_a: assert property (st_r.cfg[REG_CHAIN_OUT[2:0]][CHAIN_BIT]
    && st_r.cfg[REG_CHAIN_CFG[2:0]] == CFG_DEFAULT[23:16] |=> chain_select_out)
    else $error("chain select not asserted");

  read_done_c: cover property (st_r.fsm == ST_RDATA_ACK ##[1:1000] st_r.fsm == ST_IGNORE);
  addr_rewrite_c: cover property (byte_end && st_r.fsm == ST_WDATA && st_r.ptr == REG_DEV_ADDR);
  foreign_addr_c: cover property (byte_end && st_r.fsm == ST_ADDR ##1 st_r.fsm == ST_IGNORE);

endmodule // smbus_config_target_port

`default_nettype wire

// File: shared/smbus_cfg_pkg.sv
// Constants, state encoding and state record for the SMBus configuration target port.
// Assumes a single 200 MHz core clock that heavily oversamples the SMBus pins.
package smbus_cfg_pkg;

  // ----------------------------------------------------------------
  // Addressing
  // ----------------------------------------------------------------
  localparam logic [6:0] DEF_TARGET_ADDR = 7'h57;
  localparam logic [6:0] ARP_DEFAULT_ADDR = 7'h61;

  // ----------------------------------------------------------------
  // Register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_DEV_ADDR = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h01;
  localparam logic [7:0] REG_CHAIN_CFG = 8'h02;
  localparam logic [7:0] REG_CHAIN_OUT = 8'h07;
  localparam logic [7:0] NUM_REGS = 8'h08;
  localparam int SRST_BIT = 0;
  localparam int ANALOG_DIS_BIT = 4;
  localparam int GPIO_OE_BIT = 0;
  localparam int GPIO_MODE_LSB = 4;
  localparam int CHAIN_BIT = 0;
  localparam logic [3:0] GPIO_MODE_GP_OUT = 4'h0;
  localparam logic [7:0] RESET_WMASK = 8'h10;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_BIT_IDX = 4'h7;

  // ----------------------------------------------------------------
  // Reset values (entry 0 unused: the address lives in its own field)
  // ----------------------------------------------------------------
  localparam logic [63:0] CFG_DEFAULT = 64'h0000_0005_0505_0000;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK,
    ST_IGNORE
  } port_fsm_e;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    logic cs_s1;
    logic cs_s2;
    port_fsm_e fsm;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic rw;
    logic mack;
    logic drive;
    logic chain;
    logic [6:0] dev_addr;
    logic [7:0][7:0] cfg;
  } port_state_s;

  localparam port_state_s STATE_RESET = '{
    scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
    sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
    cs_s1: 1'b0, cs_s2: 1'b0,
    fsm: ST_IDLE, cnt: 4'h0, shreg: 8'h00, ptr: 8'h00,
    rw: 1'b0, mack: 1'b0, drive: 1'b0, chain: 1'b0,
    dev_addr: DEF_TARGET_ADDR, cfg: CFG_DEFAULT};

endpackage

// File: dv/smbus_host_model.sv
// Behavioural SMBus host that drives clock, data and port select of one target.
// Assumes the target pulls data low through an enable and the wire has a pull-up.
`timescale 1ns/1ps
`default_nettype none

module smbus_host_model
(
  // Clock
  input wire logic clk_in,
  // Target side
  input wire logic dev_oe_in,
  // Bus pins
  output logic scl_out,
  output wire logic sda_out,
  output logic select_out
);
  logic host_low;
  logic tied;

  // ----------------------------------------------------------------
  // Wire resolution
  // ----------------------------------------------------------------
  // Released data floats up through the pull-up
  assign sda_out = ~(host_low | dev_oe_in);

  initial
  begin
    scl_out = 1'b1;
    host_low = 1'b0;
    select_out = 1'b0;
    tied = 1'b0;
  end

  // ----------------------------------------------------------------
  // Bit level
  // ----------------------------------------------------------------
  // Edges land just after the clock so the target never races the host
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // Works from idle and as a repeated start from a low clock
  task automatic start_cond();
    host_low = 1'b0;
    wait_cyc(4);
    scl_out = 1'b1;
    wait_cyc(8);
    host_low = 1'b1;
    wait_cyc(8);
    scl_out = 1'b0;
    wait_cyc(4);
  endtask

  task automatic stop_cond();
    host_low = 1'b1;
    wait_cyc(4);
    scl_out = 1'b1;
    wait_cyc(8);
    host_low = 1'b0;
    wait_cyc(8);
  endtask

  // Clock low 8 cycles, high 8 cycles: twice the minimum the target needs
  task automatic bit_io(input logic b, output logic seen);
    host_low = ~b;
    wait_cyc(4);
    scl_out = 1'b1;
    wait_cyc(4);
    seen = sda_out;
    wait_cyc(4);
    scl_out = 1'b0;
    wait_cyc(4);
  endtask

  task automatic xfer_byte(input logic [7:0] tx, input logic ack_bit, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_bit, ack);
  endtask

  // ----------------------------------------------------------------
  // Transactions
  // ----------------------------------------------------------------
  task automatic read_reg(input logic sel, input logic [6:0] a, input logic [7:0] p, output logic [7:0] d,
                          output logic acked);
    logic [7:0] rx;
    logic k0, k1, k2, nk;
    select_out = sel;
    wait_cyc(6);
    start_cond();
    xfer_byte({a, 1'b0}, 1'b1, rx, k0);
    xfer_byte(p, 1'b1, rx, k1);
    start_cond();
    xfer_byte({a, 1'b1}, 1'b1, rx, k2);
    xfer_byte(8'hFF, 1'b1, d, nk);
    stop_cond();
    select_out = tied;
    wait_cyc(6);
    acked = ~(k0 | k1 | k2);
  endtask

  task automatic write_reg(input logic [6:0] a, input logic [7:0] p, input logic [7:0] v, output logic acked);
    logic [7:0] rx;
    logic k0, k1, k2;
    select_out = 1'b1;
    wait_cyc(6);
    start_cond();
    xfer_byte({a, 1'b0}, 1'b1, rx, k0);
    xfer_byte(p, 1'b1, rx, k1);
    xfer_byte(v, 1'b1, rx, k2);
    stop_cond();
    select_out = tied;
    wait_cyc(6);
    acked = ~(k0 | k1 | k2);
  endtask

  // A lone target may have its select held high for good
  task automatic tie_select(input logic t);
    tied = t;
    select_out = t;
  endtask

  // Host acknowledges the first byte, so the target moves on to the next register
  task automatic read_pair(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d0,
                           output logic [7:0] d1);
    logic [7:0] rx;
    logic k0, k1, k2, k3, nk;
    select_out = 1'b1;
    wait_cyc(6);
    start_cond();
    xfer_byte({a, 1'b0}, 1'b1, rx, k0);
    xfer_byte(p, 1'b1, rx, k1);
    start_cond();
    xfer_byte({a, 1'b1}, 1'b1, rx, k2);
    xfer_byte(8'hFF, 1'b0, d0, k3);
    xfer_byte(8'hFF, 1'b1, d1, nk);
    stop_cond();
    select_out = tied;
    wait_cyc(6);
  endtask
endmodule // smbus_host_model

`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the SMBus configuration target port.
// Assumes one 200 MHz clock and the host model as the only bus master.
`timescale 1ns/1ps
`default_nettype none

module tb
  import smbus_cfg_pkg::*;
;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  int oe_count = 0;
  int bad_count = 0;
  int checks_done = 0;
  wire logic scl, sda, sel, oe, chain, adis, sdo;
  logic [7:0] d;
  logic [7:0] d2;
  logic ok;

  always #2.5 ref_clk = ~ref_clk;

  // Only this process writes the count; scenarios compare against a snapshot
  always @(posedge ref_clk)
  begin
    if (oe)
      oe_count <= oe_count + 1;
  end

  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  smbus_config_target_port smbus_config_target_port_inst (
    .ref_clk_in(ref_clk), .nrst_in(nrst), .port_select_in(sel), .scl_in(scl), .sda_in(sda),
    .sda_out(sdo), .sda_oe_out(oe), .chain_select_out(chain), .analog_disable_out(adis));

  smbus_host_model smbus_host_model_inst (
    .clk_in(ref_clk), .dev_oe_in(oe), .scl_out(scl), .sda_out(sda), .select_out(sel));

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (bad_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults();
    smbus_host_model_inst.read_reg(1'b1, DEF_TARGET_ADDR, 8'h00, d, ok);
    check({7'h00, ok}, 8'h01);
    check({7'h00, sdo}, 8'h00);
    check(d, {DEF_TARGET_ADDR, 1'b0});
    check(d, 8'hAE);
    smbus_host_model_inst.read_reg(1'b1, DEF_TARGET_ADDR, 8'h02, d, ok);
    check(d, 8'h05);
  endtask

  // A deselected access must leave the wire untouched
  task automatic t_deselect(input logic [6:0] a);
    int oe_base;
    oe_base = oe_count;
    smbus_host_model_inst.read_reg(1'b0, a, 8'h00, d, ok);
    check({7'h00, ok}, 8'h00);
    check({7'h00, oe_count != oe_base}, 8'h00);
  endtask

  task automatic t_readdress();
    smbus_host_model_inst.write_reg(DEF_TARGET_ADDR, 8'h00, 8'h44, ok);
    check({7'h00, ok}, 8'h01);
    smbus_host_model_inst.read_reg(1'b1, DEF_TARGET_ADDR, 8'h00, d, ok);
    check({7'h00, ok}, 8'h00);
    smbus_host_model_inst.read_reg(1'b1, 7'h22, 8'h00, d, ok);
    check(d, 8'h44);
    smbus_host_model_inst.write_reg(7'h22, 8'h01, 8'h10, ok);
    check({7'h00, adis}, 8'h01);
    smbus_host_model_inst.write_reg(7'h22, 8'h01, 8'h01, ok);
    check({7'h00, adis}, 8'h00);
    smbus_host_model_inst.read_reg(1'b1, 7'h22, 8'h00, d, ok);
    check(d, 8'h44);
  endtask

  task automatic t_chain();
    check({7'h00, chain}, 8'h00);
    smbus_host_model_inst.write_reg(7'h22, 8'h07, 8'h01, ok);
    check({7'h00, chain}, 8'h01);
    smbus_host_model_inst.write_reg(7'h22, 8'h07, 8'h00, ok);
    check({7'h00, chain}, 8'h00);
  endtask

  // Select tied high as for a lone target: back-to-back reads with no deselect between them
  task automatic t_lone();
    smbus_host_model_inst.tie_select(1'b1);
    smbus_host_model_inst.read_pair(7'h22, 8'h04, d, d2);
    check({7'h00, sel}, 8'h01);
    check(d, CFG_DEFAULT[39:32]);
    check(d2, CFG_DEFAULT[47:40]);
    smbus_host_model_inst.read_reg(1'b1, 7'h22, 8'h00, d, ok);
    check(d, 8'h44);
    smbus_host_model_inst.tie_select(1'b0);
  endtask

  // Last on purpose: the port becomes unreachable afterwards
  task automatic t_arp();
    int oe_base;
    smbus_host_model_inst.write_reg(7'h22, 8'h00, {ARP_DEFAULT_ADDR, 1'b0}, ok);
    oe_base = oe_count;
    smbus_host_model_inst.read_reg(1'b1, ARP_DEFAULT_ADDR, 8'h00, d, ok);
    check({7'h00, ok}, 8'h00);
    check({7'h00, oe_count != oe_base}, 8'h00);
  endtask

  initial
  begin
    repeat (6) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
    t_defaults();
    t_deselect(DEF_TARGET_ADDR);
    t_readdress();
    t_deselect(7'h22);
    t_chain();
    t_lone();
    t_arp();
    complete_run();
  end

  // About 10k cycles expected; four times that is a hang
  initial
  begin
    #200000;
    bad_count++;
    complete_run();
  end
endmodule // tb

`default_nettype wire
